// *** pkg/pwo_pkg.sv ***
// constants for the modulated output generator: register addresses,
// field positions, reset values, counter limits and the overflow vector.
// assumes an 8-bit special function register space on the processor side.
package pwo_pkg;

    // register addresses in the special function register space
    localparam logic [7:0] PWO_ADDR_IRQ_ENABLE = 8'hAD;
    localparam logic [7:0] PWO_ADDR_COMPARE = 8'h8E;
    localparam logic [7:0] PWO_ADDR_PRESCALE = 8'h8F;
    localparam logic [7:0] PWO_ADDR_DRIVE_ENABLE = 8'hFE;

    // field positions
    localparam int PWO_BIT_GLOBAL_GATE = 7;
    localparam int PWO_BIT_OVF_MASK = 3;
    localparam int PWO_BIT_DRIVE_EN = 0;

    // reset values
    localparam logic [7:0] PWO_RST_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] PWO_RST_COMPARE = 8'h00;
    localparam logic [7:0] PWO_RST_PRESCALE = 8'h00;
    localparam logic [7:0] PWO_RST_DRIVE_ENABLE = 8'hFE;
    // unused drive enable bits read back as ones
    localparam logic [7:0] PWO_DRIVE_ENABLE_FILL = 8'hFE;

    // counter runs 0 .. 254, so one period is 255 counts
    localparam logic [7:0] PWO_CNT_LAST = 8'hFE;
    localparam logic [7:0] PWO_CNT_ZERO = 8'h00;

    // program address taken on the overflow interrupt
    localparam logic [15:0] PWO_OVF_VECTOR = 16'h0033;

endpackage

// *** hw/pwo_prescaler.sv ***
// prescaler: halves the oscillator clock, then divides by one plus the
// programmed value, giving one count tick per 2*(1+value) clk_sys cycles.
// assumes clk_sys is the oscillator and run is low in idle and power-down.
`timescale 1ns/100ps
`default_nettype none

module pwo_prescaler
    import pwo_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // control
    input wire logic run,
    input wire logic [7:0] prescale_value,
    // tick towards the counter
    output logic tick
);

    logic half;
    logic next_half;
    logic [7:0] pre_cnt;
    logic [7:0] next_pre_cnt;
    logic next_tick;

    // divide by two, then count machine cycles up to the programmed value
    always_comb
    begin
        next_half = half;
        next_pre_cnt = pre_cnt;
        next_tick = 1'b0;
        if (run)
        begin
            next_half = ~half; // the oscillator-to-machine divide by two
            if (half)
            begin
                // >= guards against a smaller value written mid-count
                if (pre_cnt >= prescale_value)
                begin
                    next_pre_cnt = PWO_CNT_ZERO;
                    next_tick = 1'b1;
                end
                else
                begin
                    next_pre_cnt = pre_cnt + 8'h01;
                end
            end
        end
    end

    // registers only
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            half <= 1'b0;
            pre_cnt <= PWO_CNT_ZERO;
            tick <= 1'b0;
        end
        else
        begin
            half <= next_half;
            pre_cnt <= next_pre_cnt;
            tick <= next_tick;
        end
    end

endmodule

`default_nettype wire

// *** hw/pwo_counter.sv ***
// modulo 255 counter with compare: sets the level on a match, clears it
// at zero, and pulses overflow on the wrap from 254 to 0.
// assumes tick is a one-cycle pulse from the prescaler.
`timescale 1ns/100ps
`default_nettype none

module pwo_counter
    import pwo_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // count step and compare value
    input wire logic tick,
    input wire logic [7:0] compare_value,
    // results
    output logic [7:0] count,
    output logic level,
    output logic overflow
);

    logic [7:0] next_count;
    logic next_level;
    logic next_overflow;

    // step on each tick; the match test runs on the value just entered
    always_comb
    begin
        next_count = count;
        next_level = level;
        next_overflow = 1'b0;
        if (tick)
        begin
            if (count == PWO_CNT_LAST)
            begin
                next_count = PWO_CNT_ZERO; // wrap after 254
                next_overflow = 1'b1; // the wrap is the overflow event
            end
            else
            begin
                next_count = count + 8'h01;
            end
            // match checked first so compare 0 keeps the level high
            if (next_count == compare_value)
            begin
                next_level = 1'b1;
            end
            else if (next_count == PWO_CNT_ZERO)
            begin
                next_level = 1'b0;
            end
        end
    end

    // registers only; 255 never matches a 0..254 count, so it stays low
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            count <= PWO_CNT_ZERO;
            level <= 1'b0;
            overflow <= 1'b0;
        end
        else
        begin
            count <= next_count;
            level <= next_level;
            overflow <= next_overflow;
        end
    end

endmodule

`default_nettype wire

// *** hw/pwo_top.sv ***
// modulated output generator with overflow interrupt: register file on the
// special function register port, pin multiplexing and interrupt request.
// assumes single-cycle register strobes synchronous to clk_sys and that the
// processor acknowledges the interrupt with a one-cycle pulse.
`timescale 1ns/100ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////

// Contract
// - counter clock comes from a dedicated programmable 8-bit prescaler.
// - counter steps 0 to 254 and wraps to 0, 255 counts per period.
// - output goes high when counter equals the compare value.
// - output goes low when counter reaches zero.
// - compare 0 keeps output high; compare 255 keeps it low.
// - enabled output drives the pin actively, strongly pulled up when high.
// - disabled output leaves an ordinary port bit; prescaler and counter keep running.
// - generator disabled during reset and until software enables it again.
// - output held high during power-down and idle.
// - counter does not advance while the processor is idle.
// - repetition rate is oscillator / 2 / (1 + prescale) / 255.
// - each counter overflow raises an interrupt unless masked.
// - enable bit 7 gates all sources; bit 3 unmasks counter overflow.
// - the overflow interrupt vectors to program address 0033H.
// - with output disabled, overflow interrupt still serves as interval timer.
module pwo_top
    import pwo_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // low-power states
    input wire logic idle_mode,
    input wire logic power_down,
    // port bit used when the output is disabled
    input wire logic port_latch_bit,
    output logic port_pin_read,
    // modulated output pin, oe_n low while the pin is driven
    input wire logic modulated_output_pin_in,
    output logic modulated_output_pin_out,
    output logic modulated_output_pin_oe_n,
    // interrupt to the processor
    input wire logic irq_ack,
    output logic irq_req,
    output logic [15:0] irq_vector,
    // observation
    output logic [7:0] pwm_count
);

    //////////////////////////////////////////////////////////////////////////
    // address decode, used by both the write and the read path

    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] reg_addr);
        addr_is = (addr == reg_addr);
    endfunction

    function automatic logic addr_mapped(input logic [7:0] addr);
        addr_mapped = addr_is(addr, PWO_ADDR_IRQ_ENABLE) ||
                      addr_is(addr, PWO_ADDR_COMPARE) ||
                      addr_is(addr, PWO_ADDR_PRESCALE) ||
                      addr_is(addr, PWO_ADDR_DRIVE_ENABLE);
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // register file

    logic [7:0] irq_enable_reg;
    logic [7:0] compare_value_reg;
    logic [7:0] prescale_value_reg;
    logic output_drive_enable_reg;
    logic [7:0] next_irq_enable_reg;
    logic [7:0] next_compare_value_reg;
    logic [7:0] next_prescale_value_reg;
    logic next_output_drive_enable_reg;
    logic [7:0] next_sfr_rdata;
    logic next_sfr_hit;
    logic overflow_irq_mask_bit;
    logic global_irq_gate_bit;

    assign overflow_irq_mask_bit = irq_enable_reg[PWO_BIT_OVF_MASK];
    assign global_irq_gate_bit = irq_enable_reg[PWO_BIT_GLOBAL_GATE];

    // writes land on the next edge; the other enable bits are kept for software
    always_comb
    begin
        next_irq_enable_reg = irq_enable_reg;
        next_compare_value_reg = compare_value_reg;
        next_prescale_value_reg = prescale_value_reg;
        next_output_drive_enable_reg = output_drive_enable_reg;
        if (sfr_wr)
        begin
            if (addr_is(sfr_addr, PWO_ADDR_IRQ_ENABLE))
            begin
                next_irq_enable_reg = sfr_wdata;
            end
            if (addr_is(sfr_addr, PWO_ADDR_COMPARE))
            begin
                next_compare_value_reg = sfr_wdata;
            end
            if (addr_is(sfr_addr, PWO_ADDR_PRESCALE))
            begin
                next_prescale_value_reg = sfr_wdata;
            end
            if (addr_is(sfr_addr, PWO_ADDR_DRIVE_ENABLE))
            begin
                next_output_drive_enable_reg = sfr_wdata[PWO_BIT_DRIVE_EN];
            end
        end
    end

    // read data is registered, one cycle after the strobe; unmapped reads give 0
    always_comb
    begin
        next_sfr_rdata = 8'h00;
        next_sfr_hit = 1'b0;
        if (sfr_rd)
        begin
            next_sfr_hit = addr_mapped(sfr_addr);
            if (addr_is(sfr_addr, PWO_ADDR_IRQ_ENABLE))
            begin
                next_sfr_rdata = irq_enable_reg;
            end
            else if (addr_is(sfr_addr, PWO_ADDR_COMPARE))
            begin
                next_sfr_rdata = compare_value_reg;
            end
            else if (addr_is(sfr_addr, PWO_ADDR_PRESCALE))
            begin
                next_sfr_rdata = prescale_value_reg;
            end
            else if (addr_is(sfr_addr, PWO_ADDR_DRIVE_ENABLE))
            begin
                next_sfr_rdata = PWO_DRIVE_ENABLE_FILL | {7'h00, output_drive_enable_reg};
            end
        end
    end

    // register stage; the enable bit is cleared by reset and stays so until software writes it
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            irq_enable_reg <= PWO_RST_IRQ_ENABLE;
            compare_value_reg <= PWO_RST_COMPARE;
            prescale_value_reg <= PWO_RST_PRESCALE;
            output_drive_enable_reg <= PWO_RST_DRIVE_ENABLE[PWO_BIT_DRIVE_EN];
            sfr_rdata <= 8'h00;
            sfr_hit <= 1'b0;
        end
        else
        begin
            irq_enable_reg <= next_irq_enable_reg;
            compare_value_reg <= next_compare_value_reg;
            prescale_value_reg <= next_prescale_value_reg;
            output_drive_enable_reg <= next_output_drive_enable_reg;
            sfr_rdata <= next_sfr_rdata;
            sfr_hit <= next_sfr_hit;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // prescaler and counter

    logic count_run;
    logic count_tick;
    logic pwm_level;
    logic count_overflow;

    // frozen in idle and power-down; the drive enable does not stop it
    assign count_run = ~idle_mode & ~power_down;

    pwo_prescaler u_prescaler
    (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .run(count_run),
        .prescale_value(prescale_value_reg),
        .tick(count_tick)
    );

    pwo_counter u_counter
    (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .tick(count_tick),
        .compare_value(compare_value_reg),
        .count(pwm_count),
        .level(pwm_level),
        .overflow(count_overflow)
    );

    //////////////////////////////////////////////////////////////////////////
    // pin multiplexing

    logic next_pin_out;
    logic next_pin_oe_n;
    logic next_port_pin_read;

    // enabled: push-pull drive, high also in low-power states; disabled: a
    // quasi-bidirectional bit that only pulls low and otherwise floats to the pullup
    always_comb
    begin
        next_pin_out = 1'b1;
        next_pin_oe_n = 1'b1;
        next_port_pin_read = modulated_output_pin_in;
        if (output_drive_enable_reg)
        begin
            next_pin_oe_n = 1'b0; // strong drive held for both levels
            next_pin_out = (idle_mode | power_down) ? 1'b1 : pwm_level;
        end
        else
        begin
            next_pin_out = 1'b0;
            next_pin_oe_n = port_latch_bit; // ordinary port bit behaviour
        end
    end

    // registered so the pin never glitches on a decode change
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            modulated_output_pin_out <= 1'b1;
            modulated_output_pin_oe_n <= 1'b1; // released while in reset
            port_pin_read <= 1'b1;
        end
        else
        begin
            modulated_output_pin_out <= next_pin_out;
            modulated_output_pin_oe_n <= next_pin_oe_n;
            port_pin_read <= next_port_pin_read;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // overflow interrupt

    logic ovf_pending;
    logic next_ovf_pending;

    // sticky pending flag; a new overflow in the acknowledge cycle wins
    always_comb
    begin
        next_ovf_pending = ovf_pending;
        if (irq_ack)
        begin
            next_ovf_pending = 1'b0;
        end
        if (count_overflow)
        begin
            next_ovf_pending = 1'b1; // set on every overflow
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ovf_pending <= 1'b0;
        end
        else
        begin
            ovf_pending <= next_ovf_pending;
        end
    end

    // masking only hides the request; the pending flag keeps the event
    assign irq_req = ovf_pending & overflow_irq_mask_bit & global_irq_gate_bit;
    assign irq_vector = PWO_OVF_VECTOR;

endmodule

`default_nettype wire

// *** bench/pwo_props.sv ***
// checker: port-level properties of pwo_top
// assumes one clock domain, bound onto every pwo_top instance
`timescale 1ns/100ps
`default_nettype none
module pwo_props
    import pwo_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // register writes
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    // low power, port latch, interrupt
    input wire logic idle_mode,
    input wire logic power_down,
    input wire logic port_latch_bit,
    input wire logic irq_ack,
    input wire logic irq_req,
    input wire logic [15:0] irq_vector,
    // pin and counter
    input wire logic modulated_output_pin_out,
    input wire logic modulated_output_pin_oe_n,
    input wire logic [7:0] pwm_count
);
default clocking cb @(posedge clk_sys);
endclocking
default disable iff (sys_rst);
////////////////////////////////////////
// shadows of written registers; quiet waits for a wrap after any write,
// since a new compare value only settles once the counter passes zero
logic [7:0] ie_q, next_ie_q, cmp_q, next_cmp_q, prev_q;
logic en_q, next_en_q, wrap_now, low_pwr;
logic [1:0] quiet_q, next_quiet_q;
assign wrap_now = (prev_q == PWO_CNT_LAST) && (pwm_count == PWO_CNT_ZERO);
assign low_pwr = idle_mode || power_down;
always_comb
begin
    next_ie_q = (sfr_wr && sfr_addr == PWO_ADDR_IRQ_ENABLE) ? sfr_wdata : ie_q;
    next_cmp_q = (sfr_wr && sfr_addr == PWO_ADDR_COMPARE) ? sfr_wdata : cmp_q;
    next_en_q = en_q;
    if (sfr_wr && sfr_addr == PWO_ADDR_DRIVE_ENABLE)
        next_en_q = sfr_wdata[PWO_BIT_DRIVE_EN];
    next_quiet_q = quiet_q;
    if (sfr_wr)
        next_quiet_q = 2'h0;
    else if ((quiet_q != 2'h0 || wrap_now) && quiet_q != 2'h3)
        next_quiet_q = quiet_q + 2'h1;
end
// registered shadows; prev_q needs no reset
always_ff @(posedge clk_sys)
begin
    prev_q <= pwm_count;
    ie_q <= sys_rst ? PWO_RST_IRQ_ENABLE : next_ie_q;
    cmp_q <= sys_rst ? PWO_RST_COMPARE : next_cmp_q;
    en_q <= sys_rst ? 1'b0 : next_en_q;
    quiet_q <= sys_rst ? 2'h0 : next_quiet_q;
end
////////////////////////////////////////
sequence s_wrap;
    ($past(pwm_count) == PWO_CNT_LAST) && (pwm_count == PWO_CNT_ZERO);
endsequence
sequence s_gate_on;
    ie_q[PWO_BIT_GLOBAL_GATE] && ie_q[PWO_BIT_OVF_MASK];
endsequence
a_vector_fixed: assert property (irq_vector == PWO_OVF_VECTOR)
    else $error("overflow vector differs");
a_count_step: assert property ($changed(pwm_count) |-> pwm_count ==
    (($past(pwm_count) == PWO_CNT_LAST) ? PWO_CNT_ZERO : $past(pwm_count) + 8'h01))
    else $error("counter step wrong");
a_idle_freeze: assert property (idle_mode [*3] |-> $stable(pwm_count))
    else $error("counter moved in idle");
a_irq_gate: assert property (irq_req |-> s_gate_on)
    else $error("request while gated");
a_irq_raise: assert property (s_wrap ##1 s_gate_on |-> irq_req)
    else $error("overflow raised no request");
a_ack_clears: assert property (irq_ack && !wrap_now |=> !irq_req)
    else $error("acknowledge left request");
a_drive_on: assert property ($past(en_q) |-> !modulated_output_pin_oe_n)
    else $error("enabled pin not driven");
a_port_mode: assert property (!$past(sys_rst) && !$past(en_q) |->
    !modulated_output_pin_out && modulated_output_pin_oe_n == $past(port_latch_bit))
    else $error("disabled pin not port bit");
a_low_pwr_high: assert property ($past(low_pwr) && $past(en_q) |->
    modulated_output_pin_out)
    else $error("output low in low power");
a_cmp_ends: assert property (quiet_q == 2'h3 && en_q && !$past(low_pwr) &&
    (cmp_q == 8'h00 || cmp_q == 8'hFF) |-> modulated_output_pin_out == (cmp_q == 8'h00))
    else $error("end compare level wrong");
endmodule
bind pwo_top pwo_props props_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .idle_mode(idle_mode), .power_down(power_down),
    .port_latch_bit(port_latch_bit), .irq_ack(irq_ack), .irq_req(irq_req),
    .irq_vector(irq_vector), .modulated_output_pin_out(modulated_output_pin_out),
    .modulated_output_pin_oe_n(modulated_output_pin_oe_n), .pwm_count(pwm_count));
`default_nettype wire

// *** bench/pwo_top_tb.sv ***
// bench for pwo_top: registers, waveform, interrupt, low power
// assumes the pwo_props checker is compiled alongside
`timescale 1ns/100ps
`default_nettype none
module pwo_top_tb
    import pwo_pkg::*;
;
logic clk_sys, sys_rst, sfr_wr, sfr_rd, sfr_hit, idle_mode, power_down, irq_ack, irq_req;
logic port_latch_bit, port_pin_read, pin_in, pin_out, pin_oe_n;
logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, pwm_count;
logic [15:0] irq_vector;
int num_errors = 0;
int num_checks = 0;
// pull-up holds the pin high when nobody drives it
assign pin_in = pin_oe_n ? 1'b1 : pin_out;
pwo_top dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .idle_mode(idle_mode), .power_down(power_down), .port_latch_bit(port_latch_bit),
    .port_pin_read(port_pin_read), .modulated_output_pin_in(pin_in),
    .modulated_output_pin_out(pin_out), .modulated_output_pin_oe_n(pin_oe_n),
    .irq_ack(irq_ack), .irq_req(irq_req), .irq_vector(irq_vector), .pwm_count(pwm_count));
initial
begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
end
////////////////////////////////////////
task check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        num_errors++;
    end
endtask
task final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask
task timeout;
    num_errors++;
    final_report;
endtask
task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
endtask
// answer stands one cycle after the strobe, seen here half a cycle in
task rd_chk(input logic [7:0] a, input logic [8:0] exp);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    check({7'h00, sfr_hit, sfr_rdata}, {7'h00, exp});
endtask
task ack;
    @(negedge clk_sys);
    irq_ack = 1'b1;
    @(negedge clk_sys);
    irq_ack = 1'b0;
endtask
task wait_cnt(input logic [7:0] v);
    int n;
    n = 0;
    while (pwm_count !== v)
    begin
        @(negedge clk_sys);
        n++;
        // longest period in this bench is 1530 clocks, so a longer wait means a hang
        if (n > 4000)
            timeout;
    end
endtask
task wait_wrap;
    wait_cnt(PWO_CNT_LAST);
    wait_cnt(PWO_CNT_ZERO);
endtask
// one wrap-to-wrap period; high time over a whole period is phase-free
task measure(input logic [7:0] cmp, input logic [7:0] p);
    int n;
    int hi;
    logic [7:0] prev;
    wr(PWO_ADDR_COMPARE, cmp);
    wr(PWO_ADDR_PRESCALE, p);
    wait_wrap;
    wait_wrap;
    n = 0;
    hi = 0;
    prev = 8'h00;
    while (!(prev === PWO_CNT_LAST && pwm_count === PWO_CNT_ZERO))
    begin
        prev = pwm_count;
        @(negedge clk_sys);
        n++;
        hi += int'(pin_out === 1'b1);
        if (n > 4000)
            timeout;
    end
    check(16'(n), 16'(510 * (p + 1)));
    check(16'(hi), 16'((255 - cmp) * 2 * (p + 1)));
endtask
////////////////////////////////////////
task t_regs;
    rd_chk(PWO_ADDR_IRQ_ENABLE, {1'b1, PWO_RST_IRQ_ENABLE});
    rd_chk(PWO_ADDR_COMPARE, {1'b1, PWO_RST_COMPARE});
    rd_chk(PWO_ADDR_PRESCALE, {1'b1, PWO_RST_PRESCALE});
    rd_chk(PWO_ADDR_DRIVE_ENABLE, {1'b1, PWO_RST_DRIVE_ENABLE});
    rd_chk(8'h80, 9'h000);
    wr(PWO_ADDR_IRQ_ENABLE, 8'h5A);
    rd_chk(PWO_ADDR_IRQ_ENABLE, 9'h15A);
    check(irq_vector, PWO_OVF_VECTOR);
endtask
task t_wave;
    wr(PWO_ADDR_DRIVE_ENABLE, 8'h01);
    rd_chk(PWO_ADDR_DRIVE_ENABLE, 9'h1FF);
    check({15'h0000, pin_oe_n}, 16'h0000);
    measure(8'h00, 8'h00);
    measure(8'h01, 8'h00);
    measure(8'h80, 8'h01);
    measure(8'hFE, 8'h00);
    measure(8'hFF, 8'h02);
endtask
// output off: pin is a port bit, overflow still serves as a timer
task t_irq;
    wr(PWO_ADDR_DRIVE_ENABLE, 8'h00);
    port_latch_bit = 1'b0;
    wr(PWO_ADDR_IRQ_ENABLE, 8'h88);
    ack;
    check({15'h0000, pin_oe_n}, 16'h0000);
    check({15'h0000, port_pin_read}, 16'h0000);
    wait_wrap;
    @(negedge clk_sys);
    check({15'h0000, irq_req}, 16'h0001);
    ack;
    check({15'h0000, irq_req}, 16'h0000);
    wr(PWO_ADDR_IRQ_ENABLE, 8'h08);
    wait_wrap;
    @(negedge clk_sys);
    check({15'h0000, irq_req}, 16'h0000);
    wr(PWO_ADDR_IRQ_ENABLE, 8'h88);
    check({15'h0000, irq_req}, 16'h0001);
    ack;
    wr(PWO_ADDR_IRQ_ENABLE, 8'h80);
    wait_wrap;
    @(negedge clk_sys);
    check({15'h0000, irq_req}, 16'h0000);
    port_latch_bit = 1'b1;
endtask
task t_low_power;
    logic [7:0] c;
    wr(PWO_ADDR_DRIVE_ENABLE, 8'h01);
    idle_mode = 1'b1;
    repeat (3) @(negedge clk_sys);
    c = pwm_count;
    repeat (40) @(negedge clk_sys);
    check({8'h00, pwm_count}, {8'h00, c});
    check({15'h0000, pin_out}, 16'h0001);
    idle_mode = 1'b0;
    power_down = 1'b1;
    repeat (3) @(negedge clk_sys);
    check({15'h0000, pin_out}, 16'h0001);
    power_down = 1'b0;
    // a second reset must leave the output switched off
    sys_rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    check({15'h0000, pin_oe_n}, {15'h0000, port_latch_bit});
    rd_chk(PWO_ADDR_DRIVE_ENABLE, {1'b1, PWO_RST_DRIVE_ENABLE});
endtask
initial
begin
    sys_rst = 1'b1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    idle_mode = 1'b0;
    power_down = 1'b0;
    port_latch_bit = 1'b1;
    irq_ack = 1'b0;
    repeat (12) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_regs;
    t_wave;
    t_irq;
    t_low_power;
    final_report;
end
endmodule
`default_nettype wire
